//--- src/synth_cfg_pkg.sv
package synth_cfg_pkg;

	// Register offsets on the configuration port
	localparam logic [5:0] ADDR_PACKET_FILTER = 6'h09;
	localparam logic [5:0] ADDR_CHANNEL = 6'h0A;
	localparam logic [5:0] ADDR_BASE_FREQUENCY_WORD_HIGH = 6'h0D;
	localparam logic [5:0] ADDR_BASE_FREQUENCY_WORD_MIDDLE = 6'h0E;
	localparam logic [5:0] ADDR_BASE_FREQUENCY_WORD_LOW = 6'h0F;
	localparam logic [5:0] ADDR_RATE_EXP = 6'h10;
	localparam logic [5:0] ADDR_RATE_MANT = 6'h11;

	// Reset values
	localparam logic [7:0] RST_PACKET_FILTER = 8'h00;
	localparam logic [7:0] RST_CHANNEL = 8'h00;
	localparam logic [5:0] RST_BASE_FREQUENCY_WORD_HIGH = 6'h1E;
	localparam logic [7:0] RST_BASE_FREQUENCY_WORD_MIDDLE = 8'hC4;
	localparam logic [7:0] RST_BASE_FREQUENCY_WORD_LOW = 8'hEC;
	localparam logic [3:0] RST_RATE_EXP = 4'hC;
	localparam logic [7:0] RST_RATE_MANT = 8'h22;

	// Field layout
	localparam int BASE_FREQUENCY_WORD_HIGH_W = 6;
	localparam int RATE_EXP_W = 4;
	localparam int BASE_FREQUENCY_WORD_W = 24;
	localparam int MANT_W = 9;
	localparam logic [7:0] BROADCAST_LOW = 8'h00;
	localparam logic [7:0] BROADCAST_HIGH = 8'hFF;

	// Settings presented to the synthesizer and modulator
	typedef struct packed {
		logic [BASE_FREQUENCY_WORD_W-1:0] base_frequency_word;
		logic [7:0] channel_index;
		logic [MANT_W-1:0] rate_mantissa;
		logic [RATE_EXP_W-1:0] rate_exponent;
	} synth_cfg_t;

endpackage : synth_cfg_pkg

//--- src/carrier_word_calc.sv
// Carrier word and symbol-rate step, both registered
module carrier_word_calc #(
	parameter int SPACING_W = 16,
	parameter int CARRIER_W = 32
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire synth_cfg_pkg::synth_cfg_t cfg,
	input wire logic [SPACING_W-1:0] channel_spacing,
	output logic [CARRIER_W-1:0] carrier_word,
	output logic [23:0] rate_step
);

	generate
		if (CARRIER_W < SPACING_W + 9 || CARRIER_W < synth_cfg_pkg::BASE_FREQUENCY_WORD_W + 1) begin : g_bad_width
			$error("carrier_word_calc: CARRIER_W too narrow");
		end
	endgenerate

	logic [SPACING_W+7:0] channel_index_offset;

	// Channel times spacing; 8x SPACING_W product fits SPACING_W+8 bits
	assign channel_index_offset = (SPACING_W+8)'(cfg.channel_index) * (SPACING_W+8)'(channel_spacing);

	// Base plus channel offset gives the carrier [RULE_02]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			carrier_word <= '0;
		end else begin
			carrier_word <= CARRIER_W'(cfg.base_frequency_word) + CARRIER_W'(channel_index_offset);
		end
	end

	// Mantissa shifted by exponent; rate = step / 2^28 * crystal_frequency [RULE_07]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rate_step <= '0;
		end else begin
			rate_step <= 24'(cfg.rate_mantissa) << cfg.rate_exponent; // 511<<15 still fits 24 bits
		end
	end

endmodule : carrier_word_calc

//--- src/synth_rate_config_regs.sv
// Overview of operation
// RULE_01: Hold 8-bit packet filter address, reset zero; 0x00 and 0xFF optionally broadcast.
// RULE_02: Channel is unsigned 8-bit, times channel spacing, added to base frequency.
// RULE_03: Top two bits of high frequency byte read zero, writes ignored.
// RULE_04: 24-bit frequency word from high, middle, low bytes; unit crystal/2^16.
// RULE_05: Rate exponent is low four bits of its register, unsigned.
// RULE_06: Upper four bits of exponent register reserved, read zero.
// RULE_07: Mantissa gets hidden leading one; rate=(256+m)*2^e/2^28*crystal.
// RULE_08: Reset loads exponent twelve and mantissa thirty-four.
// RULE_09: Settings driven continuously, updated the cycle after a write.
module synth_rate_config_regs #(
	parameter int SPACING_W = 16,
	parameter int CARRIER_W = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Configuration port, one strobe per transfer
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [5:0] cfg_addr,
	input wire logic [7:0] cfg_wr_data,
	output logic [7:0] cfg_rd_data,
	output logic cfg_rd_hit,
	// Packet address filter
	input wire logic [7:0] packet_address,
	input wire logic broadcast_low_en,
	input wire logic broadcast_high_en,
	output logic address_match,
	// Synthesizer and modulator side
	input wire logic [SPACING_W-1:0] channel_spacing,
	output synth_cfg_pkg::synth_cfg_t synth_cfg,
	output logic [CARRIER_W-1:0] carrier_word,
	output logic [23:0] rate_step
);

	// Refuse widths that the carrier arithmetic cannot hold
	generate
		if (SPACING_W < 1) begin : g_bad_spacing
			$error("synth_rate_config_regs: SPACING_W must be at least 1");
		end
		if (CARRIER_W < SPACING_W + 9 || CARRIER_W < synth_cfg_pkg::BASE_FREQUENCY_WORD_W + 1) begin : g_bad_carrier
			$error("synth_rate_config_regs: CARRIER_W too narrow for base plus channel offset");
		end
	endgenerate

	// Stored fields; reserved bits are not kept, so they cannot read back nonzero
	logic [7:0] packet_filter_address_ff;
	logic [7:0] channel_number_ff;
	logic [synth_cfg_pkg::BASE_FREQUENCY_WORD_HIGH_W-1:0] base_frequency_word_word_high_ff;
	logic [7:0] base_frequency_word_word_middle_ff;
	logic [7:0] base_frequency_word_word_low_ff;
	logic [synth_cfg_pkg::RATE_EXP_W-1:0] rate_exponent_ff;
	logic [7:0] rate_mantissa_ff;
	logic [7:0] nxt_rd_data;
	logic nxt_rd_hit;

	// One write strobe per mapped offset
	// Decoded once, so each register block sees the same decision
	logic wr_filter;
	logic wr_channel;
	logic wr_base_frequency_word_high;
	logic wr_base_frequency_word_middle;
	logic wr_base_frequency_word_low;
	logic wr_rate_exp;
	logic wr_rate_mant;

	// Write strobe for one offset
	function automatic logic wr_hit(input logic en, input logic [5:0] addr, input logic [5:0] offset);
		wr_hit = en && (addr == offset);
	endfunction : wr_hit

	// Own address always accepted; a broadcast value only while its enable is high
	function automatic logic filter_accept(
		input logic [7:0] pkt,
		input logic [7:0] own,
		input logic low_en,
		input logic high_en
	);
		filter_accept = (pkt == own) ||
			(low_en && pkt == synth_cfg_pkg::BROADCAST_LOW) ||
			(high_en && pkt == synth_cfg_pkg::BROADCAST_HIGH);
	endfunction : filter_accept

	// Offset decode; an unmapped write raises no strobe and is dropped
	assign wr_filter = wr_hit(cfg_wr_en, cfg_addr, synth_cfg_pkg::ADDR_PACKET_FILTER);
	assign wr_channel = wr_hit(cfg_wr_en, cfg_addr, synth_cfg_pkg::ADDR_CHANNEL);
	assign wr_base_frequency_word_high = wr_hit(cfg_wr_en, cfg_addr, synth_cfg_pkg::ADDR_BASE_FREQUENCY_WORD_HIGH);
	assign wr_base_frequency_word_middle = wr_hit(cfg_wr_en, cfg_addr, synth_cfg_pkg::ADDR_BASE_FREQUENCY_WORD_MIDDLE);
	assign wr_base_frequency_word_low = wr_hit(cfg_wr_en, cfg_addr, synth_cfg_pkg::ADDR_BASE_FREQUENCY_WORD_LOW);
	assign wr_rate_exp = wr_hit(cfg_wr_en, cfg_addr, synth_cfg_pkg::ADDR_RATE_EXP);
	assign wr_rate_mant = wr_hit(cfg_wr_en, cfg_addr, synth_cfg_pkg::ADDR_RATE_MANT);

	// Packet filter address [RULE_01]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			packet_filter_address_ff <= synth_cfg_pkg::RST_PACKET_FILTER;
		end else if (wr_filter) begin
			packet_filter_address_ff <= cfg_wr_data;
		end
	end

	// Channel number, taken as unsigned [RULE_02]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			channel_number_ff <= synth_cfg_pkg::RST_CHANNEL;
		end else if (wr_channel) begin
			channel_number_ff <= cfg_wr_data;
		end
	end

	// High frequency byte; only six bits are stored [RULE_03] [RULE_04]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			base_frequency_word_word_high_ff <= synth_cfg_pkg::RST_BASE_FREQUENCY_WORD_HIGH;
		end else if (wr_base_frequency_word_high) begin
			base_frequency_word_word_high_ff <= cfg_wr_data[synth_cfg_pkg::BASE_FREQUENCY_WORD_HIGH_W-1:0];
		end
	end

	// Middle frequency byte; no shadowing, so a partial update is seen at once [RULE_04]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			base_frequency_word_word_middle_ff <= synth_cfg_pkg::RST_BASE_FREQUENCY_WORD_MIDDLE;
		end else if (wr_base_frequency_word_middle) begin
			base_frequency_word_word_middle_ff <= cfg_wr_data;
		end
	end

	// Low frequency byte [RULE_04]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			base_frequency_word_word_low_ff <= synth_cfg_pkg::RST_BASE_FREQUENCY_WORD_LOW;
		end else if (wr_base_frequency_word_low) begin
			base_frequency_word_word_low_ff <= cfg_wr_data;
		end
	end

	// Rate exponent from the low nibble; upper nibble is dropped [RULE_05] [RULE_06] [RULE_08]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rate_exponent_ff <= synth_cfg_pkg::RST_RATE_EXP;
		end else if (wr_rate_exp) begin
			rate_exponent_ff <= cfg_wr_data[synth_cfg_pkg::RATE_EXP_W-1:0];
		end
	end

	// Rate mantissa [RULE_08]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rate_mantissa_ff <= synth_cfg_pkg::RST_RATE_MANT;
		end else if (wr_rate_mant) begin
			rate_mantissa_ff <= cfg_wr_data;
		end
	end

	// Read decode; unmapped offsets read zero and report no hit
	// The mux reads the flops, so a read beside a write to one offset returns the old value
	always_comb begin
		nxt_rd_hit = 1'b1;
		case (cfg_addr)
			synth_cfg_pkg::ADDR_PACKET_FILTER: nxt_rd_data = packet_filter_address_ff;
			synth_cfg_pkg::ADDR_CHANNEL: nxt_rd_data = channel_number_ff;
			synth_cfg_pkg::ADDR_BASE_FREQUENCY_WORD_HIGH: nxt_rd_data = {2'h0, base_frequency_word_word_high_ff}; // [RULE_03]
			synth_cfg_pkg::ADDR_BASE_FREQUENCY_WORD_MIDDLE: nxt_rd_data = base_frequency_word_word_middle_ff;
			synth_cfg_pkg::ADDR_BASE_FREQUENCY_WORD_LOW: nxt_rd_data = base_frequency_word_word_low_ff;
			synth_cfg_pkg::ADDR_RATE_EXP: nxt_rd_data = {4'h0, rate_exponent_ff}; // [RULE_06]
			synth_cfg_pkg::ADDR_RATE_MANT: nxt_rd_data = rate_mantissa_ff;
			default: begin
				nxt_rd_data = 8'h00;
				nxt_rd_hit = 1'b0;
			end
		endcase
	end

	// Read data held until the next read
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_rd_data <= 8'h00;
		end else if (cfg_rd_en) begin
			cfg_rd_data <= nxt_rd_data;
		end
	end

	// Hit flag travels with the read data it qualifies
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_rd_hit <= 1'b0;
		end else if (cfg_rd_en) begin
			cfg_rd_hit <= nxt_rd_hit;
		end
	end

	// Address filter; broadcast values honoured only when enabled [RULE_01]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			address_match <= 1'b0;
		end else begin
			address_match <= filter_accept(packet_address, packet_filter_address_ff, broadcast_low_en, broadcast_high_en);
		end
	end

	// Settings straight from the flops, so they follow a write by one cycle [RULE_09]
	always_comb begin
		synth_cfg.base_frequency_word = {2'h0, base_frequency_word_word_high_ff, base_frequency_word_word_middle_ff, base_frequency_word_word_low_ff}; // [RULE_04]
		synth_cfg.channel_index = channel_number_ff; // Unsigned, no extension [RULE_02]
		synth_cfg.rate_mantissa = {1'b1, rate_mantissa_ff}; // Hidden leading one [RULE_07]
		synth_cfg.rate_exponent = rate_exponent_ff; // [RULE_05]
	end

	// Carrier and rate step, one more register stage
	carrier_word_calc #(
		.SPACING_W(SPACING_W),
		.CARRIER_W(CARRIER_W)
	) carrier_word_calc_inst (
		.sys_clk(sys_clk),
		.rst(rst),
		.cfg(synth_cfg),
		.channel_spacing(channel_spacing),
		.carrier_word(carrier_word),
		.rate_step(rate_step)
	);

endmodule : synth_rate_config_regs

//--- test/synth_rate_config_regs_sva.sv
module synth_rate_config_regs_sva #(
	parameter int SPACING_W = 16,
	parameter int CARRIER_W = 32
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [5:0] cfg_addr,
	input wire logic [7:0] cfg_wr_data,
	input wire logic [7:0] cfg_rd_data,
	input wire logic cfg_rd_hit,
	input wire logic [7:0] packet_address,
	input wire logic broadcast_low_en,
	input wire logic broadcast_high_en,
	input wire logic address_match,
	input wire logic [SPACING_W-1:0] channel_spacing,
	input wire synth_cfg_pkg::synth_cfg_t synth_cfg,
	input wire logic [CARRIER_W-1:0] carrier_word,
	input wire logic [23:0] rate_step
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Reserved bits must read zero whatever was written
	hi_bits_zero_a: assert property (cfg_rd_en && cfg_addr == 6'h0D |=> cfg_rd_data[7:6] == 2'h0)
		else $error("Frequency high reserved bits nonzero");
	exp_resv_zero_a: assert property (cfg_rd_en && cfg_addr == 6'h10 |=> cfg_rd_data[7:4] == 4'h0)
		else $error("Exponent reserved bits nonzero");
	// Writes reach the settings one cycle later
	mant_write_a: assert property (cfg_wr_en && cfg_addr == 6'h11 |=> synth_cfg.rate_mantissa == {1'b1, $past(cfg_wr_data)})
		else $error("Mantissa not updated");
	exp_write_a: assert property (cfg_wr_en && cfg_addr == 6'h10 |=> synth_cfg.rate_exponent == $past(cfg_wr_data[3:0]))
		else $error("Exponent not updated");
	channel_index_write_a: assert property (cfg_wr_en && cfg_addr == 6'h0A |=> synth_cfg.channel_index == $past(cfg_wr_data))
		else $error("Channel not updated");
	base_frequency_word_low_a: assert property (cfg_wr_en && cfg_addr == 6'h0F |=> synth_cfg.base_frequency_word[7:0] == $past(cfg_wr_data))
		else $error("Frequency low byte not updated");
	// Derived words trail the settings by one cycle
	carrier_calc_a: assert property (1'b1 |=> carrier_word == $past(CARRIER_W'(synth_cfg.base_frequency_word)
		+ CARRIER_W'(synth_cfg.channel_index) * CARRIER_W'(channel_spacing))) else $error("Carrier word wrong");
	rate_step_calc_a: assert property (1'b1 |=> rate_step == $past((24'h100 + 24'(synth_cfg.rate_mantissa[7:0]))
		<< synth_cfg.rate_exponent)) else $error("Rate step wrong");
	// Broadcast values match whenever their enable is high
	bcast_low_a: assert property (broadcast_low_en && packet_address == 8'h00 |=> address_match)
		else $error("Broadcast zero not matched");
	bcast_high_a: assert property (broadcast_high_en && packet_address == 8'hFF |=> address_match)
		else $error("Broadcast all-ones not matched");
	// Default symbol rate right after reset
	rate_reset_a: assert property ($fell(rst) |-> synth_cfg.rate_exponent == 4'hC
		&& synth_cfg.rate_mantissa == 9'h122) else $error("Rate reset values wrong");

	cover property (cfg_wr_en && cfg_addr == 6'h11);
	cover property (cfg_rd_en && cfg_addr == 6'h0D);
	cover property (address_match);
endmodule : synth_rate_config_regs_sva

bind synth_rate_config_regs synth_rate_config_regs_sva #(.SPACING_W(SPACING_W), .CARRIER_W(CARRIER_W))
	synth_rate_config_regs_sva_inst (.*);

//--- test/synth_rate_config_regs_test.sv
module synth_rate_config_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, rst = 1, cfg_wr_en = 0, cfg_rd_en = 0, broadcast_low_en = 0, broadcast_high_en = 0;
	logic chk_m = 0, rd_seen = 0, m_seen = 0, cfg_rd_hit, address_match;
	logic [5:0] cfg_addr = 6'h00;
	logic [7:0] cfg_wr_data = 8'h00, packet_address = 8'h00, cfg_rd_data;
	logic [15:0] channel_spacing = 16'h0000;
	synth_cfg_pkg::synth_cfg_t synth_cfg;
	logic [31:0] carrier_word;
	logic [23:0] rate_step;
	logic [7:0] model [64];
	logic [8:0] rd_q [$];
	logic m_q [$];
	logic [100:0] s_q [$];
	int errors = 0, comparisons = 0, cycles = 0;
	logic [5:0] amap [7] = '{6'h09, 6'h0A, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11};

	synth_rate_config_regs synth_rate_config_regs_inst (.*);

	initial forever #50 sys_clk = ~sys_clk;

	task automatic conclude;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude

	task automatic chk_rd(input logic [8:0] e, input logic [8:0] s);
		comparisons++;
		if (e !== s) begin
			errors++;
			$display("MISMATCH read {hit,data} exp %h got %h", e, s);
		end
	endtask : chk_rd

	task automatic chk_match(input logic e, input logic s);
		comparisons++;
		if (e !== s) begin
			errors++;
			$display("MISMATCH address_match exp %b got %b", e, s);
		end
	endtask : chk_match

	task automatic chk_synth(input logic [100:0] e, input logic [100:0] s);
		comparisons++;
		if (e !== s) begin
			errors++;
			$display("MISMATCH {synth_cfg,carrier_word,rate_step} exp %h got %h", e, s);
		end
	endtask : chk_synth

	// Results appear one edge after the request; sampled mid-cycle to stay clear of the edge
	always @(posedge sys_clk) begin
		rd_seen <= cfg_rd_en;
		m_seen <= chk_m;
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			errors++;
			conclude();
		end
	end
	always @(negedge sys_clk) begin
		if (rd_seen) chk_rd(rd_q.pop_front(), {cfg_rd_hit, cfg_rd_data});
		if (m_seen) chk_match(m_q.pop_front(), address_match);
		if (m_seen) chk_synth(s_q.pop_front(), {synth_cfg, carrier_word, rate_step});
	end

	// One request per cycle; read, match and derived-word expectations use the model before this cycle's write lands, settings the model after it
	task automatic op(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
		logic hit;
		logic [55:0] drv;
		@(posedge sys_clk);
		#1;
		hit = a inside {6'h09, 6'h0A, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11};
		case ($urandom_range(3))
			0: packet_address = model[9];
			1: packet_address = 8'h00;
			2: packet_address = 8'hFF;
			default: packet_address = 8'($urandom);
		endcase
		broadcast_low_en = 1'($urandom);
		broadcast_high_en = 1'($urandom);
		channel_spacing = 16'($urandom);
		{cfg_wr_en, cfg_rd_en, cfg_addr, cfg_wr_data, chk_m} = {w, r, a, d, 1'b1};
		if (r) rd_q.push_back({hit, hit ? model[a] : 8'h00});
		m_q.push_back(packet_address == model[9] || (broadcast_low_en && packet_address == 8'h00)
			|| (broadcast_high_en && packet_address == 8'hFF));
		// Derived words use the settings before this write and the spacing just driven
		drv = {32'({model[13][5:0], model[14], model[15]}) + 32'(model[10]) * 32'(channel_spacing),
			(24'h000100 + 24'(model[17])) << model[16][3:0]};
		if (w && hit) model[a] = d & (a == 6'h0D ? 8'h3F : a == 6'h10 ? 8'h0F : 8'hFF);
		s_q.push_back({2'h0, model[13][5:0], model[14], model[15], model[10], 1'b1, model[17], model[16][3:0], drv});
	endtask : op

	initial begin
		void'($urandom(32'hD9DB));
		foreach (model[i]) model[i] = 8'h00;
		{model[13], model[14], model[15], model[16], model[17]} = {8'h1E, 8'hC4, 8'hEC, 8'h0C, 8'h22};
		repeat (5) @(posedge sys_clk);
		#1 rst = 0;
		// Reset values, then an unmapped offset
		foreach (amap[i]) op(0, 1, amap[i], 8'h00);
		op(0, 1, 6'h00, 8'h00);
		// All ones with a same-cycle read of the old value, then readback
		foreach (amap[i]) op(1, 1, amap[i], 8'hFF);
		foreach (amap[i]) op(0, 1, amap[i], 8'h00);
		// Random mixed traffic, mostly mapped offsets
		repeat (300) op(1'($urandom), 1'($urandom), $urandom_range(3) ? amap[$urandom_range(6)] : 6'($urandom), 8'($urandom));
		@(posedge sys_clk);
		#1 {cfg_wr_en, cfg_rd_en, chk_m} = 3'h0;
		repeat (3) @(posedge sys_clk);
		// Every note must have met its result
		if (rd_q.size() + m_q.size() + s_q.size() != 0) begin
			errors++;
			$display("MISMATCH leftover notes exp 0 got %0d", rd_q.size() + m_q.size() + s_q.size());
		end
		conclude();
	end
endmodule : synth_rate_config_regs_test
